// ===== ussl_top.sv
// module: synchronous slave serial port with apb registers and interrupt
//
// Operation
// - clear clock source bit: slave, external clock
// - keep shifting in every low-power mode
// - first queued word moves to shifter at once
// - second word waits, empty flag stays clear
// - refill shifter first, then set empty flag
// - empty flag raises enabled wake interrupt
// - single receive enable ignored in slave
// - continuous receive works during low power
// - completed word goes to receive buffer
// - word received sets flag, enabled interrupt wakes
// - clearing continuous receive clears error state
// - empty flag clears only by data write
// - shifter-empty status bit, no interrupt
`timescale 1ns/10ps
module ussl_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic shift_clock_pin,
   input wire logic dt_in,
   output logic dt_out,
   output logic dt_oe,
   output logic irq
);
   import ussl_pkg::*;

   // ----------------------------------------------------------------
   // pin synchronisers and edge finder
   // ----------------------------------------------------------------
   logic [1:0] pins_q; // bit1 clock, bit0 data, both two flops late
   logic ck_lvl; // clock after polarity choice
   logic ck_rise; // shift edge
   logic ck_fall; // sample edge

   ussl_sync #(.W(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .d({shift_clock_pin, dt_in}),
      .q(pins_q)
   );

   ussl_state_type st_ff; // all state
   ussl_state_type nxt_st; // its next value

   // polarity bit inverts the idle level of the incoming clock
   assign ck_lvl = pins_q[1] ^ st_ff.baud[BD_CKPOL];

   ussl_edge u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .lvl(ck_lvl),
      .rise(ck_rise),
      .fall(ck_fall)
   );

   // ----------------------------------------------------------------
   // decoded control
   // ----------------------------------------------------------------
   logic slave_on; // port enabled in synchronous slave mode
   logic tx_run; // transmitter allowed to move
   logic rx_run; // receiver allowed to sample
   logic setup; // apb setup cycle
   logic done; // apb access completes at this edge
   logic wr; // completing write
   logic mapped; // address hits a register
   logic [3:0] tx_bits; // word length for transmit
   logic [3:0] rx_bits; // word length for receive
   logic [8:0] rx_word; // finished word, ninth bit on top
   logic rx_last; // this falling edge ends a word
   logic [31:0] rd_mux; // read data for the addressed register
   logic [2:0] ev_set; // events raised this cycle, they beat a clear

   // no gating on sleep or idle: everything runs off the pin clock
   assign slave_on = st_ff.rx_ctrl[RC_PORT_EN] & st_ff.tx_ctrl[TX_SYNC]
      & ~st_ff.tx_ctrl[TX_CLK_SRC];
   assign tx_run = slave_on & st_ff.tx_ctrl[TX_EN];
   // single-shot enable plays no part: only continuous enable starts the receiver
   assign rx_run = slave_on & st_ff.rx_ctrl[RC_CONT_EN] & ~st_ff.ovr_err;
   assign setup = psel & ~penable;
   assign done = psel & penable & st_ff.pready;
   assign wr = done & pwrite & mapped;
   assign tx_bits = st_ff.tx_ctrl[TX_NINE_EN] ? BITS9 : BITS8;
   assign rx_bits = st_ff.rx_ctrl[RC_NINE_EN] ? BITS9 : BITS8;
   assign rx_last = rx_run & ck_fall & (st_ff.rcnt + 4'h1 == rx_bits);
   // long words arrive in all nine bits, short ones in the low eight with a zero on top
   assign rx_word = st_ff.rx_ctrl[RC_NINE_EN] ? {dt_in_s(), st_ff.rx_shift[8:1]}
      : {1'b0, dt_in_s(), st_ff.rx_shift[8:2]};

   // synchronised data pin
   function automatic logic dt_in_s();
      return pins_q[0];
   endfunction : dt_in_s

   // ----------------------------------------------------------------
   // address decode and read mux
   // ----------------------------------------------------------------
   always_comb begin
      mapped = 1'b1;
      rd_mux = '0;
      unique case (paddr)
         ADDR_RX_CTRL: begin
            rd_mux[7:0] = {st_ff.rx_ctrl[7:3], 1'b0, st_ff.ovr_err, st_ff.rbuf9};
         end
         ADDR_TX_HOLD: begin
            rd_mux[7:0] = REG_RESET; // write only
         end
         ADDR_TX_CTRL: begin
            rd_mux[7:0] = st_ff.tx_ctrl;
            rd_mux[TX_SHIFT_EMPTY] = (st_ff.tcnt == 4'h0);
         end
         ADDR_BAUD: begin
            rd_mux[7:0] = st_ff.baud;
            rd_mux[BD_RX_IDLE] = (st_ff.rcnt == 4'h0);
         end
         ADDR_DIVH: begin
            rd_mux[7:0] = st_ff.divh;
         end
         ADDR_DIVL: begin
            rd_mux[7:0] = st_ff.divl;
         end
         ADDR_RX_BUF: begin
            rd_mux[7:0] = st_ff.rbuf;
         end
         ADDR_FLAGS: begin
            rd_mux[1:0] = {st_ff.rcif, ~st_ff.hold_full};
         end
         ADDR_EVT: begin
            rd_mux[2:0] = st_ff.evt;
         end
         ADDR_MASK: begin
            rd_mux[2:0] = st_ff.mask;
         end
         default: begin
            mapped = 1'b0; // unmapped: zero data, error answer
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pready = 1'b0;
      nxt_st.pslverr = 1'b0;
      ev_set = 3'h0;

      // apb answer: one wait-free access cycle, data taken at setup
      if (setup) begin
         nxt_st.pready = 1'b1;
         nxt_st.pslverr = ~mapped;
         nxt_st.prdata = pwrite ? 32'h0000_0000 : rd_mux;
         if (!pwrite && paddr == ADDR_RX_BUF) begin
            nxt_st.rcif = 1'b0; // reading the buffer frees it
         end
      end

      // transmitter: shift out on rising edges of the pin clock
      if (!tx_run) begin
         nxt_st.tcnt = 4'h0;
      end else if (ck_rise && st_ff.tcnt > 4'h1) begin
         nxt_st.dt_out = st_ff.tx_shift[0];
         nxt_st.tx_shift = {1'b0, st_ff.tx_shift[8:1]};
         nxt_st.tcnt = st_ff.tcnt - 4'h1;
      end else if (ck_rise && st_ff.tcnt == 4'h1) begin
         nxt_st.tcnt = 4'h0; // last bit has had its full clock
      end
      // a held word only moves once the shifter is empty
      if (tx_run && st_ff.hold_full && nxt_st.tcnt == 4'h0) begin
         nxt_st.hold_full = 1'b0;
         nxt_st.evt[EV_TX] = 1'b1;
         ev_set[EV_TX] = 1'b1;
         if (ck_rise) begin
            // chained word: its first bit goes out on this same edge
            nxt_st.dt_out = st_ff.hold[0];
            nxt_st.tx_shift = {1'b0, st_ff.hold9, st_ff.hold[7:1]};
            nxt_st.tcnt = tx_bits;
         end else begin
            nxt_st.tx_shift = {st_ff.hold9, st_ff.hold};
            nxt_st.tcnt = tx_bits + 4'h1;
         end
      end
      nxt_st.dt_oe = tx_run & ~st_ff.rx_ctrl[RC_CONT_EN];

      // receiver: sample on falling edges of the pin clock
      if (!st_ff.rx_ctrl[RC_CONT_EN] || !slave_on) begin
         nxt_st.rcnt = 4'h0;
         nxt_st.ovr_err = 1'b0;
      end else if (rx_last) begin
         nxt_st.rcnt = 4'h0;
         if (nxt_st.rcif) begin
            // buffer still unread: word is lost, receiver stops
            nxt_st.ovr_err = 1'b1;
            nxt_st.evt[EV_OVR] = 1'b1;
            ev_set[EV_OVR] = 1'b1;
         end else begin
            nxt_st.rbuf = rx_word[7:0];
            nxt_st.rbuf9 = rx_word[8];
            nxt_st.rcif = 1'b1;
            nxt_st.evt[EV_RX] = 1'b1;
            ev_set[EV_RX] = 1'b1;
         end
      end else if (rx_run && ck_fall) begin
         nxt_st.rx_shift = {dt_in_s(), st_ff.rx_shift[8:1]};
         nxt_st.rcnt = st_ff.rcnt + 4'h1;
      end

      // register writes land at the completing access edge
      if (wr) begin
         unique case (paddr)
            ADDR_RX_CTRL: nxt_st.rx_ctrl = pwdata[7:0] & RX_CTRL_WMASK;
            ADDR_TX_HOLD: begin
               nxt_st.hold = pwdata[7:0];
               nxt_st.hold9 = st_ff.tx_ctrl[TX_NINTH_BIT];
               nxt_st.hold_full = 1'b1;
            end
            ADDR_TX_CTRL: nxt_st.tx_ctrl = pwdata[7:0] & TX_CTRL_WMASK;
            ADDR_BAUD: nxt_st.baud = pwdata[7:0] & BAUD_WMASK;
            ADDR_DIVH: nxt_st.divh = pwdata[7:0];
            ADDR_DIVL: nxt_st.divl = pwdata[7:0];
            // an event raised this cycle wins over the clear, even if already set
            ADDR_EVT: nxt_st.evt = (st_ff.evt & ~pwdata[2:0]) | ev_set;
            ADDR_MASK: nxt_st.mask = pwdata[2:0];
            default: nxt_st.mask = st_ff.mask; // read-only registers
         endcase
      end

      // level interrupt, no edge needed to wake from low power
      nxt_st.irq = |(nxt_st.evt & nxt_st.mask);
   end

   // ----------------------------------------------------------------
   // state register, frozen while ce is low
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign pready = st_ff.pready;
   assign pslverr = st_ff.pslverr;
   assign dt_out = st_ff.dt_out;
   assign dt_oe = st_ff.dt_oe;
   assign irq = st_ff.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic wr_hold; // completing write to the holding register
   assign wr_hold = wr & (paddr == ADDR_TX_HOLD);

   a_master_idle: assert property (ce && st_ff.tx_ctrl[TX_CLK_SRC] |=> st_ff.tcnt == 4'h0)
      else $error("shifter moved with internal clock source selected");
   a_first_moves: assert property (ce && tx_run && st_ff.hold_full && st_ff.tcnt == 4'h0
      && !wr_hold |=> !st_ff.hold_full && st_ff.tcnt != 4'h0)
      else $error("held word did not move to empty shifter");
   a_second_waits: assert property (ce && st_ff.hold_full && st_ff.tcnt > 4'h1
      |=> st_ff.hold_full)
      else $error("second word left holding register early");
   a_flag_after_load: assert property (ce && $fell(st_ff.hold_full) |-> st_ff.tcnt >= 4'h8
      && st_ff.evt[EV_TX])
      else $error("empty flag set without refill of shifter");
   a_flag_no_clear: assert property (ce && !st_ff.hold_full && !wr_hold
      |=> !st_ff.hold_full)
      else $error("empty flag cleared without data write");
   a_tx_irq: assert property (st_ff.evt[EV_TX] && st_ff.mask[EV_TX] |-> irq)
      else $error("enabled transmit event gave no interrupt");
   a_single_receive_enable_ignored: assert property (ce && !st_ff.rx_ctrl[RC_CONT_EN] |=> st_ff.rcnt == 4'h0)
      else $error("receiver ran without continuous enable");
   a_rx_store: assert property (ce && rx_last && !nxt_st.ovr_err |=> st_ff.rcif
      && st_ff.rbuf == $past(rx_word[7:0]) && st_ff.evt[EV_RX])
      else $error("finished word not placed in receive buffer");
   a_rx_irq: assert property (ce && $rose(st_ff.rcif) && st_ff.mask[EV_RX] |-> irq)
      else $error("enabled receive event gave no interrupt");
   a_err_reset: assert property (ce && !st_ff.rx_ctrl[RC_CONT_EN] |=> !st_ff.ovr_err)
      else $error("error state survived clearing continuous receive");
   a_shift_register_empty_read: assert property (ce && setup && !pwrite && paddr == ADDR_TX_CTRL
      && st_ff.tcnt == 4'h0 |=> prdata[TX_SHIFT_EMPTY] && pready)
      else $error("shifter-empty bit wrong on read");
   a_edge_order: assert property (ce && tx_run && ck_rise && st_ff.tcnt > 4'h1
      |=> dt_out == $past(st_ff.tx_shift[0]))
      else $error("transmit bit not presented on rising edge");

   c_two_words: cover property (st_ff.hold_full && st_ff.tcnt > 4'h1 ##[1:400]
      $fell(st_ff.hold_full));
   c_rx_word: cover property ($rose(st_ff.rcif));
   c_overrun: cover property ($rose(st_ff.ovr_err));
   c_irq: cover property ($rose(irq));
endmodule : ussl_top

// ===== ussl_pkg.sv
// package: register map, field positions, reset values and state layout for the sync slave port
package ussl_pkg;

   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_RX_CTRL = 8'h00; // receive_status_control
   localparam logic [7:0] ADDR_TX_HOLD = 8'h04; // transmit_holding_register
   localparam logic [7:0] ADDR_TX_CTRL = 8'h08; // transmit_status_control
   localparam logic [7:0] ADDR_BAUD = 8'h0c; // baud_control
   localparam logic [7:0] ADDR_DIVH = 8'h10; // baud_divisor_high
   localparam logic [7:0] ADDR_DIVL = 8'h14; // baud_divisor_low
   localparam logic [7:0] ADDR_RX_BUF = 8'h18; // receive_buffer_register
   localparam logic [7:0] ADDR_FLAGS = 8'h1c; // live flags, read only
   localparam logic [7:0] ADDR_EVT = 8'h20; // sticky events, write one to clear
   localparam logic [7:0] ADDR_MASK = 8'h24; // interrupt enables

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int RC_PORT_EN = 7; // serial_port_enable
   localparam int RC_NINE_EN = 6; // nine_bit_receive_enable
   localparam int RC_SINGLE_EN = 5; // single_receive_enable
   localparam int RC_CONT_EN = 4; // continuous_receive_enable
   localparam int RC_FRAME_ERR = 2; // framing_error_flag
   localparam int RC_OVR_ERR = 1; // overrun_error_flag
   localparam int RC_NINTH_BIT = 0; // received_ninth_data_bit
   localparam int TX_CLK_SRC = 7; // clock_source_select
   localparam int TX_NINE_EN = 6; // nine_bit_transmit_enable
   localparam int TX_EN = 5; // transmit_enable_bit
   localparam int TX_SYNC = 4; // synchronous mode select
   localparam int TX_SHIFT_EMPTY = 1; // shift_register_empty
   localparam int TX_NINTH_BIT = 0; // transmit_ninth_data_bit
   localparam int BD_RX_IDLE = 6; // receiver idle, read only
   localparam int BD_CKPOL = 4; // shift clock polarity invert
   localparam int EV_TX = 0; // transmit buffer went empty
   localparam int EV_RX = 1; // word received
   localparam int EV_OVR = 2; // overrun

   // ----------------------------------------------------------------
   // write masks, reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RX_CTRL_WMASK = 8'hf8;
   localparam logic [7:0] TX_CTRL_WMASK = 8'hfd;
   localparam logic [7:0] BAUD_WMASK = 8'hbb;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [2:0] EVT_RESET = 3'h0;
   localparam logic [3:0] BITS8 = 4'h8; // bits in a short word
   localparam logic [3:0] BITS9 = 4'h9; // bits in a long word

   // ----------------------------------------------------------------
   // whole state of the top module
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rx_ctrl; // control bits of receive_status_control
      logic [7:0] tx_ctrl; // control bits of transmit_status_control
      logic [7:0] baud; // baud_control storage
      logic [7:0] divh; // unused by slave, kept for software
      logic [7:0] divl;
      logic [7:0] hold; // transmit_holding_register
      logic hold9; // ninth bit taken with the held word
      logic hold_full; // inverse of transmit_buffer_empty_flag
      logic [8:0] tx_shift; // transmit_shift_register
      logic [3:0] tcnt; // bits left, plus one before first shift
      logic [8:0] rx_shift; // receive_shift_register
      logic [3:0] rcnt; // bits received so far
      logic [7:0] rbuf; // receive_buffer_register
      logic rbuf9;
      logic rcif; // receive_complete_flag
      logic ovr_err; // overrun_error_flag
      logic [2:0] evt;
      logic [2:0] mask;
      logic dt_out;
      logic dt_oe;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } ussl_state_type;

endpackage : ussl_pkg

// ===== ussl_sync.sv
// module: two-flop synchroniser for pin levels
`timescale 1ns/10ps
module ussl_sync #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // first stage is read only by the second stage
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } ussl_sync_type;

   ussl_sync_type st_ff;
   ussl_sync_type nxt_st;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st.meta = d;
      nxt_st.sync = st_ff.meta;
   end

   // register, frozen while ce is low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.sync;
endmodule : ussl_sync

// ===== ussl_edge.sv
// module: edge finder for a synchronised shift clock level
`timescale 1ns/10ps
module ussl_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic lvl,
   output logic rise,
   output logic fall
);
   // previous level only
   typedef struct packed {
      logic prev;
   } ussl_edge_type;

   ussl_edge_type st_ff;
   ussl_edge_type nxt_st;

   always_comb begin
      nxt_st.prev = lvl;
   end

   // clock idles low after reset, so a high pin at release reads as a rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // a pulse is held off while ce is low so no edge is counted twice
   assign rise = ce & lvl & ~st_ff.prev;
   assign fall = ce & ~lvl & st_ff.prev;
endmodule : ussl_edge

// ===== ussl_master_model.sv
// model of the external master that clocks the slave port
`timescale 1ns/10ps
module ussl_master_model (
   output logic sck,
   output logic m_dt,
   input wire logic dt_wire
);
   // ----------------
   // link idle levels
   // ----------------
   // clock stands still low outside frames
   initial begin
      sck = 1'b0;
      m_dt = 1'b0;
   end

   // ----------------
   // one frame
   // ----------------
   // n clocks of 80 ns, lsb first; drives m_dt and collects the pin at once
   task automatic frame(input int n, input logic [8:0] tx, output logic [8:0] rx);
      rx = 9'h000;
      #1.3; // keeps link edges out of phase with pclk
      for (int i = 0; i < n; i++) begin
         #20 m_dt = tx[i]; // data settles mid low phase, clear of both edges
         #20 sck = 1'b1; // slave shifts out its next bit here
         #40 rx[i] = dt_wire; // sampled at the falling edge
         sck = 1'b0;
      end
      #20 m_dt = ~m_dt; // released line never shows the stale bit
   endtask : frame
endmodule : ussl_master_model

// ===== usart_sync_slave_bench.sv
// self-checking bench for the synchronous slave serial port
`timescale 1ns/10ps
module usart_sync_slave_bench;
   import ussl_pkg::*;
   // ----------------
   // signals
   // ----------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1; // tied: freezing is outside this run
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, dt_out, dt_oe, irq;
   logic sck, m_dt, dt_wire;
   int err_count = 0;
   int compares = 0;
   logic [32:0] exp_q[$]; // pending reads: slave error bit, data
   logic [8:0] w0, w1, got;

   // pin level: slave drives while enabled, else the master
   assign dt_wire = dt_oe ? dt_out : m_dt;

   // 250 MHz system clock
   initial begin
      forever #2 pclk = ~pclk;
   end

   ussl_top ussl_top_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .shift_clock_pin(sck), .dt_in(dt_wire),
      .dt_out(dt_out), .dt_oe(dt_oe), .irq(irq));
   ussl_master_model ussl_master_model_inst (.sck(sck), .m_dt(m_dt), .dt_wire(dt_wire));

   // ----------------
   // tasks
   // ----------------
   task automatic chk(input logic [32:0] g, input logic [32:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wrap_up();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up

   // one apb transfer; holds everything until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         $display("BAD %0t no apb answer", $time);
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask : wr

   // notes the expected answer, then reads
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic se = 1'b0);
      exp_q.push_back({se, 24'h0, e});
      apb(1'b0, a, 32'h0);
   endtask : rd

   task automatic settle();
      repeat (4) @(posedge pclk);
   endtask : settle

   // watcher: each completed read takes the oldest note
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0)
            chk(33'h0, 33'h1);
         else
            chk({pslverr, prdata}, exp_q.pop_front());
      end
   end

   // ----------------
   // main sequence
   // ----------------
   initial begin
      void'($urandom(77));
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_RX_CTRL, REG_RESET);
      rd(ADDR_TX_CTRL, 8'h02);
      rd(ADDR_FLAGS, 8'h01);
      rd(8'h30, 8'h00, 1'b1); // unmapped place answers with an error
      // two queued words, slave clocked
      w0 = {1'b0, 8'($urandom)};
      w1 = {1'b0, 8'($urandom)};
      wr(ADDR_RX_CTRL, 8'h80);
      wr(ADDR_TX_CTRL, 8'h30);
      wr(ADDR_MASK, 8'h01);
      wr(ADDR_TX_HOLD, w0[7:0]);
      wr(ADDR_TX_HOLD, w1[7:0]);
      rd(ADDR_FLAGS, 8'h00);
      rd(ADDR_TX_CTRL, 8'h30);
      wr(ADDR_EVT, 8'h07);
      settle();
      chk(33'(irq), 33'h0);
      ussl_master_model_inst.frame(8, w0, got);
      chk(33'(got), 33'(w0));
      rd(ADDR_FLAGS, 8'h00);
      ussl_master_model_inst.frame(8, w1, got);
      chk(33'(got), 33'(w1));
      chk(33'(irq), 33'h1);
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, 8'h01);
      wr(ADDR_MASK, 8'h00);
      settle();
      chk(33'(irq), 33'h0);
      // nine-bit word, ninth bit last
      w0 = {1'b1, 8'($urandom)};
      wr(ADDR_TX_CTRL, 8'h71);
      wr(ADDR_TX_HOLD, w0[7:0]);
      ussl_master_model_inst.frame(9, w0, got);
      chk(33'(got), 33'(w0));
      wr(ADDR_TX_CTRL, 8'hb0);
      settle();
      chk(33'(dt_oe), 33'h0);
      // reception, single receive bit set too
      wr(ADDR_TX_CTRL, 8'h10);
      wr(ADDR_MASK, 8'h02);
      wr(ADDR_RX_CTRL, 8'hb0);
      w0 = {1'b0, 8'($urandom)};
      ussl_master_model_inst.frame(8, w0, got);
      settle();
      chk(33'(irq), 33'h1);
      rd(ADDR_FLAGS, 8'h03);
      rd(ADDR_RX_CTRL, 8'hb0);
      rd(ADDR_RX_BUF, w0[7:0]);
      rd(ADDR_FLAGS, 8'h01);
      wr(ADDR_RX_CTRL, 8'hd0);
      for (int i = 0; i < 2; i++) begin
         w0 = 9'($urandom);
         ussl_master_model_inst.frame(9, w0, got);
         rd(ADDR_RX_CTRL, {7'h68, w0[8]});
         rd(ADDR_RX_BUF, w0[7:0]);
      end
      // overrun, then cleared by dropping continuous receive
      wr(ADDR_EVT, 8'h07);
      wr(ADDR_RX_CTRL, 8'h90);
      w0 = {1'b0, 8'($urandom)};
      w1 = {1'b0, 8'($urandom)};
      ussl_master_model_inst.frame(8, w0, got);
      ussl_master_model_inst.frame(8, w1, got);
      rd(ADDR_RX_CTRL, 8'h92);
      rd(ADDR_EVT, 8'h06);
      wr(ADDR_RX_CTRL, 8'h80);
      rd(ADDR_RX_CTRL, 8'h80);
      rd(ADDR_RX_BUF, w0[7:0]);
      wrap_up();
   end
endmodule : usart_sync_slave_bench
